// [shared/cfg_status_consts.svh]
// Constants for the configuration status port of the link core
// Notes on behaviour
// - Link-down high when LinkUp false, else low
// - LinkUp true in Recovery, L0, L0s, L1, L2
// - Configuration via Detect-Polling means LinkUp false
// - Link-down held zero during reset
// - Link status codes: none, training, DL pending, done
// - Width four bits, valid only when status 11b
// - Speed codes 001b, 010b, 100b from speed bits
// - Max payload from device control bits 7:5
// - User never sends payload beyond max payload
// - Max read request from device control bits 14:12
// - User read requests never exceed max read size
// - Four command bits per function, eight bits total
// - User gates requests, completions per function enables
`ifndef CFG_STATUS_CONSTS_SVH
`define CFG_STATUS_CONSTS_SVH

// ==========================================================
// Port widths
`define LTSSM_W        4
`define LINK_STAT_W    2
`define WIDTH_W        4
`define SPEED_W        3
`define SIZE_CODE_W    3
`define FUNC_NUM       2
`define FUNC_BITS      4
`define FUNC_STAT_W    8
`define REG16_W        16
`define BYTES_W        13

// ==========================================================
// Link status codes
`define LS_NO_RCVR     2'h0
`define LS_TRAINING    2'h1
`define LS_DL_PENDING  2'h2
`define LS_DL_DONE     2'h3

// ==========================================================
// Link status register fields
`define SPEED_LSB      0
`define SPEED_FLD_W    2
`define NWIDTH_LSB     4
`define SPD_FLD_2G5    2'h1
`define SPD_FLD_5G     2'h2
`define SPD_FLD_8G     2'h3
`define SPD_2G5        3'h1
`define SPD_5G         3'h2
`define SPD_8G         3'h4
`define SPD_NONE       3'h0

// ==========================================================
// Device control register fields
`define MPS_LSB        5
`define MRRS_LSB       12

// ==========================================================
// Command register fields
`define CMD_IO_BIT     0
`define CMD_MEM_BIT    1
`define CMD_BME_BIT    2
`define CMD_INTX_BIT   10
`define FS_IO          0
`define FS_MEM         1
`define FS_BME         2
`define FS_INTX        3

// ==========================================================
// Size codes and byte counts
`define SIZE_CODE_MAX  3'h5
`define SIZE_BASE      13'h0080

// ==========================================================
// Reset values
`define RST_LINK_DOWN  1'b0

`endif

// [shared/cfg_status_pkg.sv]
// Types shared by both ends of the configuration status port
`include "cfg_status_consts.svh"

package cfg_status_pkg;

	// ======================================================
	// Training state machine states
	typedef enum logic [`LTSSM_W-1:0] {
		LT_DETECT   = 4'h0,
		LT_POLLING  = 4'h1,
		LT_CONFIG   = 4'h2,
		LT_RECOVERY = 4'h3,
		LT_L0       = 4'h4,
		LT_L0S      = 4'h5,
		LT_L1       = 4'h6,
		LT_L2       = 4'h7,
		LT_DISABLED = 4'h8,
		LT_LOOPBACK = 4'h9,
		LT_HOTRESET = 4'hA
	} ltssm_e;

	// ======================================================
	// State of the status source
	typedef struct packed {
		ltssm_e                    prev;
		logic                      poll_from_det;
		logic                      cfg_linkup;
		logic                      link_down;
		logic [`LINK_STAT_W-1:0]   link_status;
		logic [`WIDTH_W-1:0]       width;
		logic [`SPEED_W-1:0]       speed;
		logic [`SIZE_CODE_W-1:0]   mps;
		logic [`SIZE_CODE_W-1:0]   mrrs;
		logic [`FUNC_STAT_W-1:0]   func;
	} src_state_s;

	// ======================================================
	// State of the status user
	typedef struct packed {
		logic                      link_ready;
		logic [`WIDTH_W-1:0]       width;
		logic [`BYTES_W-1:0]       mps_bytes;
		logic [`BYTES_W-1:0]       mrrs_bytes;
		logic                      tx_len_ok;
		logic                      rd_len_ok;
		logic [`FUNC_NUM-1:0]      req_allow;
		logic [`FUNC_NUM-1:0]      cpl_allow;
		logic [`FUNC_NUM-1:0]      intx_allow;
	} snk_state_s;

	// ======================================================
	// Size code to byte count; reserved codes give the floor
	function automatic logic [`BYTES_W-1:0] size_bytes(
		input logic [`SIZE_CODE_W-1:0] code
	);
		logic [`BYTES_W-1:0] b;
		b = `SIZE_BASE;
		if (code <= `SIZE_CODE_MAX) begin
			b = `SIZE_BASE << code;
		end
		return b;
	endfunction : size_bytes

endpackage : cfg_status_pkg

// [shared/cfg_status_if.sv]
// Interface joining the status source and the status user
`timescale 1ns/100ps
`include "cfg_status_consts.svh"

interface cfg_status_if (
	input wire logic clk
);
	logic                      link_down;
	logic [`LINK_STAT_W-1:0]   link_status;
	logic [`WIDTH_W-1:0]       negotiated_width;
	logic [`SPEED_W-1:0]       current_speed;
	logic [`SIZE_CODE_W-1:0]   max_payload;
	logic [`SIZE_CODE_W-1:0]   max_read_req;
	logic [`FUNC_STAT_W-1:0]   function_status;

	// Core side drives, user side observes
	modport src (
		output link_down, link_status, negotiated_width,
		output current_speed, max_payload, max_read_req,
		output function_status
	);
	modport snk (
		input link_down, link_status, negotiated_width,
		input current_speed, max_payload, max_read_req,
		input function_status
	);
endinterface : cfg_status_if

// [rtl/cfg_status_src.sv]
// Core end: derives the status outputs from link and config state
`timescale 1ns/100ps
`include "cfg_status_consts.svh"

module cfg_status_src
	import cfg_status_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// Physical and data link layer state
	input  wire ltssm_e                   ltssm,
	input  wire logic                     dl_active,
	// Configuration space registers
	input  wire logic [`REG16_W-1:0]      link_stat_reg,
	input  wire logic [`REG16_W-1:0]      dev_ctrl_reg,
	input  wire logic [`REG16_W-1:0]      cmd_reg_f0,
	input  wire logic [`REG16_W-1:0]      cmd_reg_f1,
	// Status port toward the user logic
	cfg_status_if.src                     st
);

	// ======================================================
	// State
	src_state_s                           s_q;
	src_state_s                           s_d;
	logic                                 entering;
	logic                                 linkup;
	logic [`SPEED_FLD_W-1:0]              spd_fld;
	logic [`REG16_W-1:0]                  cmd_regs [`FUNC_NUM];
	logic [`FUNC_STAT_W-1:0]              func_bits;
	// Decoded training history and speed
	logic                                 poll_entry;
	logic                                 cfg_entry;
	logic                                 via_det_poll;
	logic                                 in_detect;
	logic [`SPEED_W-1:0]                  speed_code;

	// ======================================================
	// Command registers gathered per function
	assign cmd_regs[0] = cmd_reg_f0;
	assign cmd_regs[1] = cmd_reg_f1;

	// Speed field of the link status register
	assign spd_fld = link_stat_reg[`SPEED_LSB +: `SPEED_FLD_W];

	// A state change seen this cycle
	assign entering = (ltssm != s_q.prev);

	// Entry strobes for the two states whose history matters
	assign poll_entry = entering && (ltssm == LT_POLLING);
	assign cfg_entry  = entering && (ltssm == LT_CONFIG);

	// Configuration reached through Detect then Polling keeps LinkUp low
	assign via_det_poll = (s_q.prev == LT_POLLING) && s_q.poll_from_det;

	// Detect means no receivers, whatever the LinkUp history
	assign in_detect = (ltssm == LT_DETECT);

	// ======================================================
	// Speed field to one-hot speed code; the unused field
	// value gives no speed at all
	function automatic logic [`SPEED_W-1:0] speed_of(
		input logic [`SPEED_FLD_W-1:0] fld
	);
		logic [`SPEED_W-1:0] code;
		code = `SPD_NONE;
		unique case (fld)
			`SPD_FLD_2G5: begin
				code = `SPD_2G5;
			end
			`SPD_FLD_5G: begin
				code = `SPD_5G;
			end
			`SPD_FLD_8G: begin
				code = `SPD_8G;
			end
			default: begin
				code = `SPD_NONE;
			end
		endcase
		return code;
	endfunction : speed_of

	// One-hot speed from the link status register
	assign speed_code = speed_of(spd_fld);

	// ======================================================
	// Four command bits per function
	genvar gf;
	generate
		for (gf = 0; gf < `FUNC_NUM; gf++) begin : g_func
			// Space decode enables for I/O and memory
			assign func_bits[gf*`FUNC_BITS + `FS_IO] =
				cmd_regs[gf][`CMD_IO_BIT];
			assign func_bits[gf*`FUNC_BITS + `FS_MEM] =
				cmd_regs[gf][`CMD_MEM_BIT];
			// Bus master enable
			assign func_bits[gf*`FUNC_BITS + `FS_BME] =
				cmd_regs[gf][`CMD_BME_BIT];
			// Interrupt disable sits high in the command register
			assign func_bits[gf*`FUNC_BITS + `FS_INTX] =
				cmd_regs[gf][`CMD_INTX_BIT];
		end
	endgenerate

	// ======================================================
	// Next state
	always_comb begin
		// Hold by default; the training state is tracked every cycle
		s_d = s_q;
		s_d.prev = ltssm;

		// Remember whether Polling was reached from Detect
		if (poll_entry) begin
			s_d.poll_from_det = (s_q.prev == LT_DETECT);
		end

		// Decide LinkUp on entry to Configuration; the decision
		// then holds for as long as the state lasts
		if (cfg_entry) begin
			s_d.cfg_linkup = !via_det_poll;
		end

		// LinkUp from the current training state
		unique case (ltssm)
			LT_RECOVERY,
			LT_L0,
			LT_L0S,
			LT_L1,
			LT_L2: begin
				linkup = 1'b1;
			end
			// Configuration follows the decision taken on entry
			LT_CONFIG: begin
				linkup = s_d.cfg_linkup;
			end
			// Detect, Polling, Disabled, Loopback, Hot Reset
			default: begin
				linkup = 1'b0;
			end
		endcase

		// Link down is the inverse of LinkUp
		s_d.link_down = !linkup;

		// Link status code
		if (in_detect) begin
			s_d.link_status = `LS_NO_RCVR;
		end else if (!linkup) begin
			s_d.link_status = `LS_TRAINING;
		end else if (!dl_active) begin
			s_d.link_status = `LS_DL_PENDING;
		end else begin
			s_d.link_status = `LS_DL_DONE;
		end

		// Negotiated width field
		s_d.width = link_stat_reg[`NWIDTH_LSB +: `WIDTH_W];

		// Current speed, one hot
		s_d.speed = speed_code;

		// Size limits from device control
		s_d.mps  = dev_ctrl_reg[`MPS_LSB +: `SIZE_CODE_W];
		s_d.mrrs = dev_ctrl_reg[`MRRS_LSB +: `SIZE_CODE_W];

		// Function command enables
		s_d.func = func_bits;

		// Reset clears everything, link down held low
		if (reset) begin
			s_d = '0;
			// Detect as history, so a first Polling counts as fresh
			s_d.prev = LT_DETECT;
			s_d.link_down = `RST_LINK_DOWN;
		end
	end

	// ======================================================
	// Register the state every clock
	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	// ======================================================
	// Drive the status port from flip-flops
	// Link down, low through reset
	assign st.link_down        = s_q.link_down;

	// Link status code
	assign st.link_status      = s_q.link_status;

	// Width field, trusted only once the data link is up
	assign st.negotiated_width = s_q.width;

	// One-hot current speed
	assign st.current_speed    = s_q.speed;

	// Payload size code, reserved codes passed through
	assign st.max_payload      = s_q.mps;

	// Read request size code, reserved codes passed through
	assign st.max_read_req     = s_q.mrrs;

	// Command enables, four bits per function
	assign st.function_status  = s_q.func;

endmodule : cfg_status_src

// [rtl/cfg_status_snk.sv]
// User end: turns status into limits and per-function permissions
`timescale 1ns/100ps
`include "cfg_status_consts.svh"

module cfg_status_snk
	import cfg_status_pkg::*;
(
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// Status port from the core
	cfg_status_if.snk                     st,
	// Lengths the user wants to send
	input  wire logic [`BYTES_W-1:0]      tx_payload_len,
	input  wire logic [`BYTES_W-1:0]      rd_req_len,
	// Limits and permissions
	output logic                          link_ready,
	output logic [`WIDTH_W-1:0]           link_width,
	output logic [`BYTES_W-1:0]           mps_bytes,
	output logic [`BYTES_W-1:0]           mrrs_bytes,
	output logic                          tx_len_ok,
	output logic                          rd_len_ok,
	output logic [`FUNC_NUM-1:0]          req_allow,
	output logic [`FUNC_NUM-1:0]          cpl_allow,
	output logic [`FUNC_NUM-1:0]          intx_allow
);

	// ======================================================
	// State
	snk_state_s                           s_q;
	snk_state_s                           s_d;
	logic                                 ready;
	logic [`BYTES_W-1:0]                  mps_b;
	logic [`BYTES_W-1:0]                  mrrs_b;

	assign ready  = (st.link_status == `LS_DL_DONE);
	assign mps_b  = size_bytes(st.max_payload);
	assign mrrs_b = size_bytes(st.max_read_req);

	// ======================================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.link_ready = ready;
		// Width only trusted once data link is up
		s_d.width = ready ? st.negotiated_width : '0;
		s_d.mps_bytes  = mps_b;
		s_d.mrrs_bytes = mrrs_b;
		s_d.tx_len_ok = ready && (tx_payload_len <= mps_b);
		s_d.rd_len_ok = ready && (rd_req_len <= mrrs_b);
		for (int f = 0; f < `FUNC_NUM; f++) begin
			s_d.req_allow[f] = ready &&
				st.function_status[f*`FUNC_BITS + `FS_BME];
			s_d.cpl_allow[f] = ready &&
				(st.function_status[f*`FUNC_BITS + `FS_MEM] ||
				 st.function_status[f*`FUNC_BITS + `FS_IO]);
			s_d.intx_allow[f] = ready &&
				!st.function_status[f*`FUNC_BITS + `FS_INTX];
		end
		if (reset) begin
			s_d = '0;
		end
	end

	// ======================================================
	// Register the state every clock
	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	// Outputs from flip-flops
	assign link_ready = s_q.link_ready;
	assign link_width = s_q.width;
	assign mps_bytes  = s_q.mps_bytes;
	assign mrrs_bytes = s_q.mrrs_bytes;
	assign tx_len_ok  = s_q.tx_len_ok;
	assign rd_len_ok  = s_q.rd_len_ok;
	assign req_allow  = s_q.req_allow;
	assign cpl_allow  = s_q.cpl_allow;
	assign intx_allow = s_q.intx_allow;

endmodule : cfg_status_snk

// [verif/cfg_status_checker.sv]
// Assertions watching the status port between the two ends
`timescale 1ns/100ps
`include "cfg_status_consts.svh"

module cfg_status_checker (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// Status port signals
	input  wire logic                     link_down,
	input  wire logic [`LINK_STAT_W-1:0]  link_status,
	input  wire logic [`WIDTH_W-1:0]      negotiated_width,
	input  wire logic [`SPEED_W-1:0]      current_speed,
	input  wire logic [`SIZE_CODE_W-1:0]  max_payload,
	input  wire logic [`SIZE_CODE_W-1:0]  max_read_req,
	input  wire logic [`FUNC_STAT_W-1:0]  function_status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// ======================================================
	// Link steps: no receivers outside the cycle after reset,
	// then training straight after
	sequence seq_idle;
		!$past(reset) && link_status == `LS_NO_RCVR;
	endsequence
	sequence seq_poll;
		seq_idle ##1 link_status == `LS_TRAINING;
	endsequence

	// ======================================================
	// Port relations
	chk_down_released: assert property ($fell(reset) |-> !link_down)
		else $error("link down not low after reset");
	chk_all_cleared: assert property ($fell(reset) |->
		{link_status, negotiated_width, current_speed, max_payload,
		max_read_req, function_status} == '0)
		else $error("status port not cleared by reset");
	chk_up_not_down: assert property (link_status[1] |-> !link_down)
		else $error("link down while link reported up");
	chk_idle_down: assert property (seq_idle |-> link_down)
		else $error("link down low with no receivers");
	chk_poll_down: assert property (seq_poll |-> link_down)
		else $error("link down low in training from idle");
	chk_rise_training: assert property ($rose(link_down) |->
		!link_status[1])
		else $error("link down rose with link up status");
	chk_fall_linked: assert property ($fell(link_down) &&
		!$past(reset) |-> link_status != `LS_NO_RCVR)
		else $error("link down fell with no receivers");
	chk_speed_code: assert property ($onehot0(current_speed))
		else $error("speed code not one hot");
endmodule : cfg_status_checker

// [verif/pcie_config_status_outputs_bench.sv]
// Bench joining status source and user through the status interface
`timescale 1ns/100ps
`include "cfg_status_consts.svh"

`define CHECK(nm, exp, got) begin tests_run++; \
	if ((got) !== (exp)) begin miscompares++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end

module pcie_config_status_outputs_bench
	import cfg_status_pkg::*;
;
	logic                  clk, reset, dl_active;
	ltssm_e                ltssm;
	logic [`REG16_W-1:0]   link_stat_reg, dev_ctrl_reg, cmd_reg_f0, cmd_reg_f1;
	logic [`BYTES_W-1:0]   tx_payload_len, rd_req_len, mps_bytes, mrrs_bytes;
	logic                  link_ready, tx_len_ok, rd_len_ok;
	logic [`WIDTH_W-1:0]   link_width;
	logic [`FUNC_NUM-1:0]  req_allow, cpl_allow, intx_allow;
	logic [2:0]            spd [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	ltssm_e                upst [5] = '{LT_RECOVERY, LT_CONFIG, LT_L0S,
		LT_L1, LT_L2};
	int                    miscompares = 0;
	int                    tests_run = 0;
	int                    fnum, cbit;

	// ======================================================
	// Clock and the two ends
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	cfg_status_if cfg_status_if_i (.clk(clk));
	cfg_status_src cfg_status_src_i (.clk(clk), .reset(reset),
		.ltssm(ltssm), .dl_active(dl_active), .link_stat_reg(link_stat_reg),
		.dev_ctrl_reg(dev_ctrl_reg), .cmd_reg_f0(cmd_reg_f0),
		.cmd_reg_f1(cmd_reg_f1), .st(cfg_status_if_i));
	cfg_status_snk cfg_status_snk_i (.clk(clk), .reset(reset),
		.st(cfg_status_if_i), .tx_payload_len(tx_payload_len),
		.rd_req_len(rd_req_len), .link_ready(link_ready),
		.link_width(link_width), .mps_bytes(mps_bytes),
		.mrrs_bytes(mrrs_bytes), .tx_len_ok(tx_len_ok),
		.rd_len_ok(rd_len_ok), .req_allow(req_allow),
		.cpl_allow(cpl_allow), .intx_allow(intx_allow));
	cfg_status_checker cfg_status_checker_i (.clk(clk), .reset(reset),
		.link_down(cfg_status_if_i.link_down),
		.link_status(cfg_status_if_i.link_status),
		.negotiated_width(cfg_status_if_i.negotiated_width),
		.current_speed(cfg_status_if_i.current_speed),
		.max_payload(cfg_status_if_i.max_payload),
		.max_read_req(cfg_status_if_i.max_read_req),
		.function_status(cfg_status_if_i.function_status));

	// ======================================================
	// Helpers
	function automatic logic [`BYTES_W-1:0] bytes_of(input logic [2:0] c);
		return (c <= 3'h5) ? 13'h0080 << c : 13'h0080;
	endfunction : bytes_of

	task wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n

	// Move the training state, then check link down and status
	task lk(input ltssm_e s, input logic dn, input logic [1:0] stt);
		ltssm = s;
		wait_n(1);
		`CHECK("link_down", dn, cfg_status_if_i.link_down)
		`CHECK("link_status", stt, cfg_status_if_i.link_status)
	endtask : lk

	task print_verdict;
		$display("Compared %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	// Watchdog against a hang
	initial begin
		repeat (1000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	// ======================================================
	// Test sequence
	initial begin
		reset = 1'b1;
		ltssm = LT_DETECT;
		dl_active = 1'b0;
		{link_stat_reg, dev_ctrl_reg, cmd_reg_f0, cmd_reg_f1} = '0;
		{tx_payload_len, rd_req_len} = '0;
		wait_n(2);
		`CHECK("link_down", 1'b0, cfg_status_if_i.link_down)
		reset = 1'b0;
		lk(LT_DETECT, 1'b1, 2'h0);
		lk(LT_POLLING, 1'b1, 2'h1);
		lk(LT_CONFIG, 1'b1, 2'h1);
		lk(LT_L0, 1'b0, 2'h2);
		dl_active = 1'b1;
		lk(LT_L0, 1'b0, 2'h3);
		wait_n(1);
		`CHECK("link_ready", 1'b1, link_ready)
		foreach (upst[i]) lk(upst[i], 1'b0, 2'h3);
		lk(LT_DISABLED, 1'b1, 2'h1);
		lk(LT_L0, 1'b0, 2'h3);
		$display("Test link walk done");
		for (int i = 0; i < 4; i++) begin
			link_stat_reg = {8'h00, 4'(2 * i + 1), 2'h0, 2'(i)};
			wait_n(2);
			`CHECK("current_speed", spd[i],
				cfg_status_if_i.current_speed)
			`CHECK("width", 4'(2 * i + 1),
				cfg_status_if_i.negotiated_width)
			`CHECK("link_width", 4'(2 * i + 1), link_width)
		end
		$display("Test speed and width done");
		for (int c = 0; c < 8; c++) begin
			dev_ctrl_reg = {1'b0, 3'(7 - c), 4'h0, 3'(c), 5'h00};
			tx_payload_len = bytes_of(3'(c)) + 13'(c % 2);
			rd_req_len = bytes_of(3'(7 - c)) + 13'(1 - c % 2);
			wait_n(2);
			`CHECK("max_payload", 3'(c),
				cfg_status_if_i.max_payload)
			`CHECK("max_read_req", 3'(7 - c),
				cfg_status_if_i.max_read_req)
			`CHECK("mps_bytes", bytes_of(3'(c)), mps_bytes)
			`CHECK("mrrs_bytes", bytes_of(3'(7 - c)), mrrs_bytes)
			`CHECK("tx_len_ok", 1'(1 - c % 2), tx_len_ok)
			`CHECK("rd_len_ok", 1'(c % 2), rd_len_ok)
		end
		$display("Test sizes done");
		for (int k = 0; k < 8; k++) begin
			fnum = k / 4;
			cbit = (k % 4 == 3) ? 10 : k % 4;
			cmd_reg_f0 = '0;
			cmd_reg_f1 = '0;
			if (fnum == 0) cmd_reg_f0[cbit] = 1'b1;
			else cmd_reg_f1[cbit] = 1'b1;
			wait_n(2);
			`CHECK("function_status", 8'h01 << k,
				cfg_status_if_i.function_status)
			`CHECK("req_allow", (k % 4 == 2) ? 2'h1 << fnum : 2'h0,
				req_allow)
			`CHECK("cpl_allow", (k % 4 < 2) ? 2'h1 << fnum : 2'h0,
				cpl_allow)
			`CHECK("intx_allow",
				(k % 4 == 3) ? 2'h3 ^ (2'h1 << fnum) : 2'h3,
				intx_allow)
		end
		$display("Test function status done");
		lk(LT_DETECT, 1'b1, 2'h0);
		wait_n(1);
		`CHECK("link_width", 4'h0, link_width)
		`CHECK("intx_allow", 2'h0, intx_allow)
		lk(LT_L0, 1'b0, 2'h3);
		reset = 1'b1;
		wait_n(2);
		`CHECK("link_down", 1'b0, cfg_status_if_i.link_down)
		reset = 1'b0;
		lk(LT_POLLING, 1'b1, 2'h1);
		lk(LT_CONFIG, 1'b1, 2'h1);
		$display("Test reset and gating done");
		print_verdict();
	end
endmodule : pcie_config_status_outputs_bench
